/* logic/input_conditioner_defines.vh */
// Register map, field positions, reset values and timing constants of the input conditioner
`ifndef INPUT_CONDITIONER_DEFINES_VH
`define INPUT_CONDITIONER_DEFINES_VH

// ==========================================================
// Register byte offsets
`define OFF_POLARITY 12'h000
`define OFF_CONFIRM_TIME 12'h004
`define OFF_UPDOWN_MODE 12'h008
`define OFF_UPDOWN_RATE 12'h00c
`define OFF_FREQ_SAVE 12'h010
`define OFF_RUN_SOURCE 12'h014
`define OFF_RUN_WIRING 12'h018
`define OFF_LOCAL_REMOTE 12'h01c
`define OFF_FUNC_MAP_LO 12'h020
`define OFF_FUNC_MAP_HI 12'h024
`define OFF_DRIVE_STATE 12'h028
`define OFF_ANGLE_IN 12'h02c
`define OFF_TERMINAL_STATE 12'h030
`define OFF_FUNC_STATUS 12'h034
`define OFF_FREQ_CMD 12'h038
`define OFF_ANGLE_DEV 12'h03c

// ==========================================================
// Reset values
`define RST_POLARITY 16'h0000
`define RST_CONFIRM_MS 15'h0005
`define RST_UPDOWN_RATE 10'h001
`define RST_FUNC_MAP 28'h0000000

// ==========================================================
// Field positions and limits
`define BIT_NO_SAVE 7
`define BIT_RUN_BY_POLARITY 1
`define CONFIRM_MAX_MS 15'h7530
`define RATE_MAX 10'h3e8
`define RATE_MIN 10'h001
`define MS_NS 1000000
`define CLK_NS 8
`define CYCLES_PER_MS (`MS_NS / `CLK_NS)

// ==========================================================
// Terminal function codes
`define FN_MASTER_DEB 7'h32
`define FN_PLC_BIT0 7'h33
`define FN_PLC_BIT1 7'h34
`define FN_QUICK_STOP 7'h35
`define FN_LOCAL_REMOTE 7'h38
`define FN_AUX_ZERO 7'h46
`define FN_PID_CLEAR 7'h47
`define FN_PID_HOLD 7'h48
`define FN_INT_INHIBIT 7'h49
`define FN_FB_REVERSE 7'h4a
`define FN_ZERO_POINT 7'h51
`define FN_OOB_DETECT 7'h52
`define FN_MOTOR_BIT0 7'h53
`define FN_MOTOR_BIT1 7'h54

`endif

/* logic/multi_input_terminal_conditioner.v */
// Input terminal conditioner with AXI4-Lite register file and function decoders
`timescale 1ns/1ps
`include "input_conditioner_defines.vh"

module multi_input_terminal_conditioner #(
	parameter N_TERM = 7,
	parameter CYCLES_PER_MS = `CYCLES_PER_MS
) (
	// Clock and reset
	input wire clk_sys,
	input wire reset_n,
	// Terminal pins
	input wire [N_TERM-1:0] multi_input_terminal,
	// Drive core status
	input wire drive_running,
	input wire canopen_control,
	input wire updown_up,
	input wire updown_down,
	// AXI4-Lite write address
	input wire [11:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	// AXI4-Lite write data
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	// AXI4-Lite write response
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// AXI4-Lite read address
	input wire [11:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	// AXI4-Lite read data
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// Decoded functions
	output reg [N_TERM-1:0] terminal_state,
	output reg decel_energy_backup,
	output reg plc_run,
	output reg plc_stop,
	output reg plc_disable,
	output reg quick_stop,
	output reg local_control,
	output reg remote_control,
	output reg local_remote_indicate,
	output reg aux_freq_zero,
	output reg pid_enable,
	output reg pid_clear,
	output reg pid_hold,
	output reg pid_integral_zero,
	output reg pid_feedback_invert,
	output reg position_trigger,
	output reg out_of_balance_detect,
	output reg [1:0] motor_index,
	output reg [1:0] updown_mode,
	output reg [19:0] freq_command
);

	// ==========================================================
	// Registers
	reg [15:0] input_contact_polarity;
	reg [14:0] input_confirm_time;
	reg [1:0] updown_mode_select;
	reg [9:0] updown_step_rate;
	reg [15:0] frequency_save_options;
	reg [15:0] run_terminal_source_select;
	reg [15:0] run_wiring_selection;
	reg [15:0] local_remote_mode_param;
	reg [27:0] func_map_lo;
	reg [20:0] func_map_hi;
	reg [31:0] angle_in;
	reg [15:0] angle_deviation_low;
	reg [15:0] angle_deviation_high;
	reg [N_TERM-1:0] sync1;
	reg [N_TERM-1:0] sync2;
	reg [19:0] ms_count;
	reg ms_tick;
	reg run_prev;
	reg up_prev;
	reg down_prev;
	reg zero_prev;
	reg aw_held;
	reg w_held;
	reg [11:0] aw_addr;
	reg [31:0] w_data;
	reg [3:0] w_strb;

	wire [48:0] func_map = {func_map_hi, func_map_lo};
	wire [N_TERM-1:0] polarity_eff;
	wire [N_TERM-1:0] conditioned;

	// ==========================================================
	// Polarity and confirmation filter
	assign polarity_eff[1:0] = (run_wiring_selection != 16'h0000) ? 2'b00 :
		input_contact_polarity[1:0];
	assign polarity_eff[N_TERM-1:2] = input_contact_polarity[N_TERM-1:2];
	// Comm-only run terminals take polarity bits as their state
	assign conditioned[1:0] = run_terminal_source_select[`BIT_RUN_BY_POLARITY] ?
		input_contact_polarity[1:0] : (sync2[1:0] ^ polarity_eff[1:0]);
	assign conditioned[N_TERM-1:2] = sync2[N_TERM-1:2] ^ polarity_eff[N_TERM-1:2];

	always @(posedge clk_sys) begin
		sync1 <= multi_input_terminal;
		sync2 <= sync1;
		if (!reset_n || ms_count == CYCLES_PER_MS - 1) begin
			ms_count <= 20'h00000;
		end else begin
			ms_count <= ms_count + 20'h00001;
		end
		ms_tick <= reset_n && (ms_count == CYCLES_PER_MS - 1);
	end

	genvar gi;
	generate
		for (gi = 0; gi < N_TERM; gi = gi + 1) begin : g_filter
			reg [14:0] hold_ms;
			always @(posedge clk_sys) begin
				if (!reset_n) begin
					hold_ms <= 15'h0000;
					terminal_state[gi] <= 1'b0;
				end else if (conditioned[gi] == terminal_state[gi]) begin
					hold_ms <= 15'h0000;
				end else if (hold_ms >= input_confirm_time) begin
					terminal_state[gi] <= conditioned[gi];
					hold_ms <= 15'h0000;
				end else if (ms_tick) begin
					hold_ms <= hold_ms + 15'h0001;
				end
			end
		end
	endgenerate

	// ==========================================================
	// Function decoding
	function fn_on;
		input [6:0] code;
		integer k;
		begin
			fn_on = 1'b0;
			for (k = 0; k < N_TERM; k = k + 1) begin
				if (func_map[k*7 +: 7] == code && terminal_state[k]) begin
					fn_on = 1'b1;
				end
			end
		end
	endfunction

	wire f_plc0 = fn_on(`FN_PLC_BIT0);
	wire f_plc1 = fn_on(`FN_PLC_BIT1);
	wire f_lr = fn_on(`FN_LOCAL_REMOTE);
	wire f_zero = fn_on(`FN_ZERO_POINT);
	wire f_up = updown_up;
	wire f_down = updown_down;

	always @(posedge clk_sys) begin
		if (!reset_n) begin
			decel_energy_backup <= 1'b0;
			plc_run <= 1'b0;
			plc_stop <= 1'b0;
			plc_disable <= 1'b1;
			quick_stop <= 1'b0;
			local_control <= 1'b0;
			remote_control <= 1'b1;
			local_remote_indicate <= 1'b0;
			aux_freq_zero <= 1'b0;
			pid_enable <= 1'b1;
			pid_clear <= 1'b0;
			pid_hold <= 1'b0;
			pid_integral_zero <= 1'b0;
			pid_feedback_invert <= 1'b0;
			position_trigger <= 1'b0;
			out_of_balance_detect <= 1'b0;
			motor_index <= 2'b00;
			zero_prev <= 1'b0;
		end else begin
			decel_energy_backup <= fn_on(`FN_MASTER_DEB);
			plc_disable <= !f_plc1 && !f_plc0;
			plc_run <= !f_plc1 && f_plc0;
			plc_stop <= f_plc1 && !f_plc0;
			quick_stop <= fn_on(`FN_QUICK_STOP) && canopen_control;
			local_control <= f_lr;
			remote_control <= !f_lr;
			local_remote_indicate <= local_remote_mode_param != 16'h0000;
			aux_freq_zero <= fn_on(`FN_AUX_ZERO);
			pid_enable <= !fn_on(`FN_PID_CLEAR) && !fn_on(`FN_PID_HOLD);
			pid_clear <= fn_on(`FN_PID_CLEAR);
			pid_hold <= fn_on(`FN_PID_HOLD) && !fn_on(`FN_PID_CLEAR);
			pid_integral_zero <= fn_on(`FN_INT_INHIBIT);
			pid_feedback_invert <= fn_on(`FN_FB_REVERSE);
			zero_prev <= f_zero;
			position_trigger <= f_zero && !zero_prev;
			out_of_balance_detect <= fn_on(`FN_OOB_DETECT);
			motor_index <= {fn_on(`FN_MOTOR_BIT1), fn_on(`FN_MOTOR_BIT0)};
		end
	end

	// ==========================================================
	// UP/DOWN frequency command, units of 0.001 Hz
	always @(posedge clk_sys) begin
		if (!reset_n) begin
			freq_command <= 20'h00000;
			updown_mode <= 2'b00;
			run_prev <= 1'b0;
			up_prev <= 1'b0;
			down_prev <= 1'b0;
		end else begin
			updown_mode <= updown_mode_select;
			run_prev <= drive_running;
			up_prev <= f_up;
			down_prev <= f_down;
			if (!drive_running && run_prev && frequency_save_options[`BIT_NO_SAVE]) begin
				freq_command <= 20'h00000;
			end else if (drive_running) begin
				case (updown_mode_select)
					2'd1: begin
						if (ms_tick && f_up && !f_down) begin
							freq_command <= freq_command + {10'h000, updown_step_rate};
						end else if (ms_tick && f_down && !f_up) begin
							freq_command <= (freq_command > {10'h000, updown_step_rate}) ?
								freq_command - {10'h000, updown_step_rate} : 20'h00000;
						end
					end
					2'd2: begin
						if (f_up && !up_prev) begin
							freq_command <= freq_command + {10'h000, updown_step_rate};
						end else if (f_down && !down_prev) begin
							freq_command <= (freq_command > {10'h000, updown_step_rate}) ?
								freq_command - {10'h000, updown_step_rate} : 20'h00000;
						end
					end
					default: begin
						freq_command <= freq_command;
					end
				endcase
			end
		end
	end

	// ==========================================================
	// AXI4-Lite slave
	wire do_write = aw_held && w_held && !s_axi_bvalid;
	reg [31:0] rd_val;
	reg rd_ok;

	always @* begin
		rd_ok = 1'b1;
		case (s_axi_araddr)
			`OFF_POLARITY: rd_val = {16'h0000, input_contact_polarity};
			`OFF_CONFIRM_TIME: rd_val = {17'h00000, input_confirm_time};
			`OFF_UPDOWN_MODE: rd_val = {30'h00000000, updown_mode_select};
			`OFF_UPDOWN_RATE: rd_val = {22'h000000, updown_step_rate};
			`OFF_FREQ_SAVE: rd_val = {16'h0000, frequency_save_options};
			`OFF_RUN_SOURCE: rd_val = {16'h0000, run_terminal_source_select};
			`OFF_RUN_WIRING: rd_val = {16'h0000, run_wiring_selection};
			`OFF_LOCAL_REMOTE: rd_val = {16'h0000, local_remote_mode_param};
			`OFF_FUNC_MAP_LO: rd_val = {4'h0, func_map_lo};
			`OFF_FUNC_MAP_HI: rd_val = {11'h000, func_map_hi};
			`OFF_DRIVE_STATE: rd_val = {30'h00000000, canopen_control, drive_running};
			`OFF_ANGLE_IN: rd_val = angle_in;
			`OFF_TERMINAL_STATE: rd_val = {25'h0000000, terminal_state};
			`OFF_FUNC_STATUS: rd_val = {16'h0000, motor_index, out_of_balance_detect,
				position_trigger, pid_feedback_invert, pid_integral_zero, pid_hold, pid_clear,
				aux_freq_zero, local_control, quick_stop, plc_stop, plc_run, plc_disable,
				decel_energy_backup, pid_enable};
			`OFF_FREQ_CMD: rd_val = {12'h000, freq_command};
			`OFF_ANGLE_DEV: rd_val = {angle_deviation_high, angle_deviation_low};
			default: begin
				rd_val = 32'h00000000;
				rd_ok = 1'b0;
			end
		endcase
	end

	always @(posedge clk_sys) begin
		if (!reset_n) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= 2'b00;
			s_axi_rdata <= 32'h00000000;
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 12'h000;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
			input_contact_polarity <= `RST_POLARITY;
			input_confirm_time <= `RST_CONFIRM_MS;
			updown_mode_select <= 2'b00;
			updown_step_rate <= `RST_UPDOWN_RATE;
			frequency_save_options <= 16'h0000;
			run_terminal_source_select <= 16'h0000;
			run_wiring_selection <= 16'h0000;
			local_remote_mode_param <= 16'h0000;
			func_map_lo <= `RST_FUNC_MAP;
			func_map_hi <= 21'h000000;
			angle_in <= 32'h00000000;
			angle_deviation_low <= 16'h0000;
			angle_deviation_high <= 16'h0000;
		end else begin
			// Angle snapshot only while out-of-balance detection is on
			if (out_of_balance_detect) begin
				angle_deviation_low <= angle_in[15:0];
				angle_deviation_high <= angle_in[31:16];
			end
			s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid;
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= 2'b00;
				if (w_strb[1:0] == 2'b11) begin
					case (aw_addr)
						`OFF_POLARITY: input_contact_polarity <= w_data[15:0];
						`OFF_CONFIRM_TIME: input_confirm_time <= (w_data > {17'h00000,
							`CONFIRM_MAX_MS}) ? `CONFIRM_MAX_MS : w_data[14:0];
						`OFF_UPDOWN_MODE: updown_mode_select <= w_data[1:0];
						`OFF_UPDOWN_RATE: updown_step_rate <= (w_data > {22'h000000, `RATE_MAX}) ?
							`RATE_MAX : ((w_data == 32'h00000000) ? `RATE_MIN : w_data[9:0]);
						`OFF_FREQ_SAVE: frequency_save_options <= w_data[15:0];
						`OFF_RUN_SOURCE: run_terminal_source_select <= w_data[15:0];
						`OFF_RUN_WIRING: run_wiring_selection <= w_data[15:0];
						`OFF_LOCAL_REMOTE: local_remote_mode_param <= w_data[15:0];
						`OFF_FUNC_MAP_LO: func_map_lo <= w_data[27:0];
						`OFF_FUNC_MAP_HI: func_map_hi <= w_data[20:0];
						`OFF_ANGLE_IN: angle_in <= w_data;
						default: s_axi_bresp <= 2'b10;
					endcase
				end else begin
					s_axi_bresp <= 2'b10;
				end
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_val;
				s_axi_rresp <= rd_ok ? 2'b00 : 2'b10;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

endmodule // multi_input_terminal_conditioner

/* tb/input_conditioner_sva.sv */
// Assertion checker for the input terminal conditioner ports
`timescale 1ns/1ps
module input_conditioner_checker (
	// Clock and reset
	input wire clk_sys,
	input wire reset_n,
	// Core status
	input wire drive_running,
	input wire canopen_control,
	// Read data channel
	input wire [31:0] s_axi_rdata,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	// Decoded functions
	input wire plc_run,
	input wire plc_stop,
	input wire plc_disable,
	input wire quick_stop,
	input wire local_control,
	input wire remote_control,
	input wire pid_enable,
	input wire pid_clear,
	input wire pid_hold,
	input wire position_trigger,
	input wire [1:0] motor_index,
	input wire [19:0] freq_command
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!reset_n);
	// ==========
	// Function decoders, UP/DOWN frequency and read data channel
	a_plc_exclusive: assert property ($onehot0({plc_run, plc_stop, plc_disable}))
		else $error("PLC outputs overlap");
	a_mode_complement: assert property (local_control != remote_control)
		else $error("Local and remote not complementary");
	a_clear_stops: assert property (pid_clear |-> !pid_enable)
		else $error("PID runs while cleared");
	a_hold_stops: assert property (pid_hold |-> !pid_enable)
		else $error("PID runs while held");
	a_trigger_pulse: assert property (position_trigger |=> !position_trigger)
		else $error("Position trigger longer than one cycle");
	a_qstop_canopen: assert property (quick_stop |-> canopen_control || $past(canopen_control))
		else $error("Quick stop without CANopen control");
	a_freq_idle: assert property (!drive_running [*4] |-> $stable(freq_command))
		else $error("Frequency moved while stopped");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("Read data dropped before taken");
	// ==========
	// Coverage
	c_plc_run: cover property (plc_run);
	c_motor_four: cover property (motor_index == 2'h3);
	c_quick_stop: cover property (quick_stop);
	c_trigger: cover property (position_trigger);
endmodule // input_conditioner_checker

bind multi_input_terminal_conditioner input_conditioner_checker input_conditioner_checker_inst (
	.clk_sys, .reset_n, .drive_running, .canopen_control, .s_axi_rdata, .s_axi_rvalid,
	.s_axi_rready, .plc_run, .plc_stop, .plc_disable, .quick_stop, .local_control,
	.remote_control, .pid_enable, .pid_clear, .pid_hold, .position_trigger, .motor_index,
	.freq_command
);

/* tb/terminal_switch_model.sv */
// Contact switches wired to the seven input terminals
`timescale 1ns/1ps
module terminal_switch_model (
	// Clock
	input wire clk_sys,
	// Contact requests
	input wire [6:0] contact,
	input wire [6:0] chatter,
	// Terminal pins
	output reg [6:0] pins
);
	initial pins = 7'h00;
	// Closed contact gives a high pin in either wiring sense; chattering pins flip each cycle
	always @(posedge clk_sys) begin
		pins <= (contact & ~chatter) | (~pins & chatter);
	end
endmodule // terminal_switch_model

/* tb/tb_multi_input_terminal_conditioner.sv */
// Self-checking testbench of the input terminal conditioner
`timescale 1ns/1ps
`include "input_conditioner_defines.vh"
module tb_multi_input_terminal_conditioner;
	localparam [1:0] OK = 2'h0;
	localparam [1:0] ERR = 2'h2;
	reg clk_sys, reset_n, drive_running, canopen_control, updown_up, updown_down;
	reg [11:0] s_axi_awaddr, s_axi_araddr;
	reg [31:0] s_axi_wdata;
	reg [3:0] s_axi_wstrb;
	reg s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0] s_axi_bresp, s_axi_rresp, motor_index, updown_mode;
	wire [31:0] s_axi_rdata;
	wire [6:0] multi_input_terminal, terminal_state;
	wire [19:0] freq_command;
	wire decel_energy_backup, plc_run, plc_stop, plc_disable, quick_stop, local_control;
	wire remote_control, local_remote_indicate, aux_freq_zero, pid_enable, pid_clear;
	wire pid_hold, pid_integral_zero, pid_feedback_invert, position_trigger;
	wire out_of_balance_detect;
	wire [7:0] fn_out = {decel_energy_backup, aux_freq_zero, pid_clear, pid_hold,
		pid_integral_zero, pid_feedback_invert, out_of_balance_detect, ~pid_enable};
	reg [6:0] contact, chatter;
	reg [6:0] fcode [0:7];
	reg [7:0] fmask [0:7];
	int error_cnt, n_compared;
	int trig_cnt = 0;

	terminal_switch_model terminal_switch_model_inst (.clk_sys(clk_sys), .contact(contact),
		.chatter(chatter), .pins(multi_input_terminal));
	multi_input_terminal_conditioner #(.N_TERM(7), .CYCLES_PER_MS(10))
		multi_input_terminal_conditioner_inst (.clk_sys, .reset_n, .multi_input_terminal,
		.drive_running, .canopen_control, .updown_up, .updown_down, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .terminal_state, .decel_energy_backup, .plc_run, .plc_stop,
		.plc_disable, .quick_stop, .local_control, .remote_control, .local_remote_indicate,
		.aux_freq_zero, .pid_enable, .pid_clear, .pid_hold, .pid_integral_zero,
		.pid_feedback_invert, .position_trigger, .out_of_balance_detect, .motor_index,
		.updown_mode, .freq_command);

	// ==========
	// Clock, watchdog, trigger counter
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	initial begin
		repeat (20000) @(posedge clk_sys);
		error_cnt++;
		report_and_stop;
	end
	always @(posedge clk_sys) begin
		if (position_trigger) trig_cnt <= trig_cnt + 1;
	end

	// ==========
	// Tasks
	task check(input [31:0] seen, input [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task report_and_stop;
		if (error_cnt == 0 && n_compared > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task tick(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	task axi_write(input [11:0] a, input [31:0] d, input [1:0] er);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		forever begin
			@(posedge clk_sys);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		s_axi_bready <= 1'b0;
		check(s_axi_bresp, er);
		@(posedge clk_sys);
	endtask
	task axi_read(input [11:0] a, input [31:0] ed, input [1:0] er);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		forever begin
			@(posedge clk_sys);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		s_axi_rready <= 1'b0;
		check(s_axi_rdata, ed);
		check(s_axi_rresp, er);
		@(posedge clk_sys);
	endtask

	// ==========
	// Tests
	initial begin
		{drive_running, canopen_control, updown_up, updown_down, s_axi_awvalid, s_axi_wvalid,
			s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr,
			s_axi_wdata, contact, chatter} = '0;
		s_axi_wstrb = 4'hf;
		reset_n = 1'b0;
		fcode = '{`FN_MASTER_DEB, `FN_AUX_ZERO, `FN_PID_CLEAR, `FN_PID_HOLD, `FN_INT_INHIBIT,
			`FN_FB_REVERSE, `FN_OOB_DETECT, `FN_ZERO_POINT};
		fmask = '{8'h80, 8'h40, 8'h21, 8'h11, 8'h08, 8'h04, 8'h02, 8'h00};
		tick(4);
		reset_n <= 1'b1;
		tick(2);
		check({plc_disable, remote_control, pid_enable, terminal_state}, 10'h380);
		axi_read(`OFF_POLARITY, 32'h0, OK);
		axi_read(`OFF_CONFIRM_TIME, 32'h5, OK);
		axi_read(`OFF_UPDOWN_RATE, 32'h1, OK);
		axi_write(`OFF_CONFIRM_TIME, 32'h9c40, OK);
		axi_read(`OFF_CONFIRM_TIME, 32'h7530, OK);
		axi_read(12'h100, 32'h0, ERR);
		axi_write(`OFF_TERMINAL_STATE, 32'h1, ERR);
		// Filter: chatter rejected, steady change delayed by 2 ms
		axi_write(`OFF_CONFIRM_TIME, 32'h2, OK);
		axi_write(`OFF_FUNC_MAP_LO, {4'h0, `FN_MOTOR_BIT1, `FN_MOTOR_BIT0, `FN_PLC_BIT1,
			`FN_PLC_BIT0}, OK);
		chatter <= 7'h10;
		tick(25);
		chatter <= 7'h00;
		tick(40);
		check(terminal_state, 7'h00);
		contact <= 7'h10;
		tick(12);
		check(terminal_state, 7'h00);
		tick(40);
		check(terminal_state, 7'h10);
		// PLC code and motor index
		axi_write(`OFF_CONFIRM_TIME, 32'h0, OK);
		for (int i = 0; i < 4; i++) begin
			contact <= {3'h0, i[1:0], i[1:0]};
			tick(12);
			check(motor_index, i);
			if (i < 3) check({plc_disable, plc_run, plc_stop}, {i == 0, i == 1, i == 2});
		end
		// Polarity word inverts before the filter
		axi_write(`OFF_POLARITY, 32'h7f, OK);
		tick(12);
		check(terminal_state, 7'h70);
		axi_write(`OFF_RUN_WIRING, 32'h1, OK);
		tick(12);
		check(terminal_state, 7'h73);
		axi_write(`OFF_RUN_WIRING, 32'h0, OK);
		axi_write(`OFF_RUN_SOURCE, 32'h2, OK);
		axi_write(`OFF_POLARITY, 32'h1, OK);
		tick(12);
		check(terminal_state, 7'h0d);
		axi_write(`OFF_RUN_SOURCE, 32'h0, OK);
		axi_write(`OFF_POLARITY, 32'h0, OK);
		contact <= 7'h00;
		// Quick stop, local/remote and function table on terminal 6
		axi_write(`OFF_LOCAL_REMOTE, 32'h1, OK);
		for (int k = 0; k < 8; k++) begin
			axi_write(`OFF_FUNC_MAP_HI, {11'h0, fcode[k], `FN_LOCAL_REMOTE, `FN_QUICK_STOP}, OK);
			contact <= 7'h70;
			canopen_control <= k[0];
			tick(12);
			check(quick_stop, k[0]);
			check({local_control, remote_control, local_remote_indicate}, 3'h5);
			check(fn_out, fmask[k]);
			if (k == 6) begin
				axi_write(`OFF_ANGLE_IN, 32'h12345678, OK);
				axi_read(`OFF_ANGLE_DEV, 32'h12345678, OK);
			end
			contact <= 7'h00;
			tick(12);
		end
		check(trig_cnt, 1);
		axi_write(`OFF_ANGLE_IN, 32'h0, OK);
		axi_read(`OFF_ANGLE_DEV, 32'h12345678, OK);
		// UP/DOWN modes, rate and stop behaviour
		for (int m = 0; m < 4; m++) begin
			axi_write(`OFF_UPDOWN_MODE, m, OK);
			check(updown_mode, m);
		end
		axi_write(`OFF_UPDOWN_RATE, 32'h3e8, OK);
		axi_write(`OFF_UPDOWN_MODE, 32'h1, OK);
		updown_up <= 1'b1;
		tick(30);
		check(freq_command, 20'h0);
		drive_running <= 1'b1;
		tick(50);
		check(freq_command >= 20'h00fa0 && freq_command <= 20'h01770, 1);
		updown_up <= 1'b0;
		axi_write(`OFF_FREQ_SAVE, 32'h80, OK);
		drive_running <= 1'b0;
		tick(5);
		check(freq_command, 20'h0);
		axi_write(`OFF_UPDOWN_MODE, 32'h2, OK);
		drive_running <= 1'b1;
		tick(3);
		updown_up <= 1'b1;
		tick(1);
		updown_up <= 1'b0;
		tick(30);
		check(freq_command, 20'h003e8);
		report_and_stop;
	end
endmodule // tb_multi_input_terminal_conditioner
